// *** core/lrar_pkg.sv ***
// constants for the legacy region access router
// Notes on behaviour
// - Setting bits 13 to 12 route reads and writes of the 16 KB region ending at 000D3FFFh.
// - Setting bits 11 to 10 route reads and writes of 000CC000h through 000CFFFFh.
// - Setting bits 9 to 8 route reads and writes of 000C8000h through 000CBFFFh.
// - A setting of 00 sends both reads and writes of the region to PCI and none to SDRAM.
// - A setting of 01 serves reads from SDRAM and sends writes to PCI.
// - A setting of 10 sends reads to PCI and puts writes into SDRAM.
// - A setting of 11 serves both reads and writes from SDRAM and sends nothing to PCI.
package lrar_pkg;
  localparam int unsigned LRAR_ADDR_W = 32;
  localparam int unsigned LRAR_ATTR_W = 32;
  // =====================================================================
  // region decode
  localparam logic [31:0] LRAR_D0_BASE = 32'h000d0000;
  localparam logic [31:0] LRAR_CC_BASE = 32'h000cc000;
  localparam logic [31:0] LRAR_C8_BASE = 32'h000c8000;
  localparam int unsigned LRAR_REGION_SHIFT = 14;
  // =====================================================================
  // setting field positions (low bit of each pair) in the attribute word
  localparam int unsigned LRAR_D0_POS = 12;
  localparam int unsigned LRAR_CC_POS = 10;
  localparam int unsigned LRAR_C8_POS = 8;
  // within a setting: bit 0 keeps reads local, bit 1 keeps writes local
  localparam int unsigned LRAR_SEL_RD_BIT = 0;
  localparam int unsigned LRAR_SEL_WR_BIT = 1;
  // =====================================================================
  // values after reset
  localparam logic LRAR_RST_REQ = 1'b0;
  localparam logic [31:0] LRAR_RST_ADDR = 32'h00000000;
  localparam logic LRAR_RST_WRITE = 1'b0;
endpackage

// *** core/lrar_router.sv ***
// legacy region access router: steers cpu requests to sdram, pci or onward decode
`timescale 1ns/100ps
module lrar_router
  import lrar_pkg::*;
#(
  parameter int unsigned ADDR_W = LRAR_ADDR_W
)
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [LRAR_ATTR_W-1:0] mem_attr_in,
  output logic sdram_req_out,
  output logic pci_req_out,
  output logic other_req_out,
  output logic req_write_out,
  output logic [ADDR_W-1:0] req_addr_out
);

  // =====================================================================
  // parameter checks
  // the region bases and the copied address are fixed at 32 bits
  if (ADDR_W != 32)
  begin : g_addr_w_check
    $error("lrar_router: ADDR_W must be 32");
  end

  if (LRAR_ATTR_W < LRAR_D0_POS + 2)
  begin : g_attr_w_check
    $error("lrar_router: attribute word too narrow for the setting fields");
  end

  // =====================================================================
  // setting fields
  logic [1:0] region_d0_route_sel;
  logic [1:0] region_cc_route_sel;
  logic [1:0] region_c8_route_sel;

  assign region_d0_route_sel = mem_attr_in[LRAR_D0_POS +: 2];
  assign region_cc_route_sel = mem_attr_in[LRAR_CC_POS +: 2];
  assign region_c8_route_sel = mem_attr_in[LRAR_C8_POS +: 2];

  // =====================================================================
  // region match and steering, one instance per region
  logic d0_hit;
  logic d0_local;
  logic cc_hit;
  logic cc_local;
  logic c8_hit;
  logic c8_local;

  lrar_region_route #(
    .ADDR_W(ADDR_W),
    .BASE(LRAR_D0_BASE),
    .BLK_SHIFT(LRAR_REGION_SHIFT)
  )
  u_d0_route
  (
    .addr_in(req_addr_in),
    .write_in(req_write_in),
    .route_sel_in(region_d0_route_sel),
    .hit_out(d0_hit),
    .local_out(d0_local)
  );

  lrar_region_route #(
    .ADDR_W(ADDR_W),
    .BASE(LRAR_CC_BASE),
    .BLK_SHIFT(LRAR_REGION_SHIFT)
  )
  u_cc_route
  (
    .addr_in(req_addr_in),
    .write_in(req_write_in),
    .route_sel_in(region_cc_route_sel),
    .hit_out(cc_hit),
    .local_out(cc_local)
  );

  lrar_region_route #(
    .ADDR_W(ADDR_W),
    .BASE(LRAR_C8_BASE),
    .BLK_SHIFT(LRAR_REGION_SHIFT)
  )
  u_c8_route
  (
    .addr_in(req_addr_in),
    .write_in(req_write_in),
    .route_sel_in(region_c8_route_sel),
    .hit_out(c8_hit),
    .local_out(c8_local)
  );

  // =====================================================================
  // next request state
  logic any_hit;
  logic sel_local;
  logic nxt_sdram_req;
  logic nxt_pci_req;
  logic nxt_other_req;
  logic nxt_write;
  logic [ADDR_W-1:0] nxt_addr;
  logic sdram_req_ff;
  logic pci_req_ff;
  logic other_req_ff;
  logic write_ff;
  logic [ADDR_W-1:0] addr_ff;

  always_comb
  begin
    any_hit = 1'b0;
    sel_local = 1'b0;
    // the regions never overlap, so the order of these tests is free
    if (d0_hit)
    begin
      any_hit = 1'b1;
      sel_local = d0_local;
    end
    else if (cc_hit)
    begin
      any_hit = 1'b1;
      sel_local = cc_local;
    end
    else if (c8_hit)
    begin
      any_hit = 1'b1;
      sel_local = c8_local;
    end
    nxt_sdram_req = req_valid_in & any_hit & sel_local;
    nxt_pci_req = req_valid_in & any_hit & ~sel_local;
    // outside the regions the request goes on untouched to the rest of the decoder
    nxt_other_req = req_valid_in & ~any_hit;
    // write flag and address follow every cycle so the targets see them with the strobe
    nxt_write = req_write_in;
    nxt_addr = req_addr_in;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sdram_req_ff <= LRAR_RST_REQ;
      pci_req_ff <= LRAR_RST_REQ;
      other_req_ff <= LRAR_RST_REQ;
      write_ff <= LRAR_RST_WRITE;
      addr_ff <= ADDR_W'(LRAR_RST_ADDR);
    end
    else
    begin
      sdram_req_ff <= nxt_sdram_req;
      pci_req_ff <= nxt_pci_req;
      other_req_ff <= nxt_other_req;
      write_ff <= nxt_write;
      addr_ff <= nxt_addr;
    end
  end

  // =====================================================================
  // outputs, each straight from its flip-flop
  assign sdram_req_out = sdram_req_ff;
  assign pci_req_out = pci_req_ff;
  assign other_req_out = other_req_ff;
  assign req_write_out = write_ff;
  assign req_addr_out = addr_ff;

endmodule

// =====================================================================
// one legacy region: 16 KB block match and read or write steering
module lrar_region_route
  import lrar_pkg::*;
#(
  parameter int unsigned ADDR_W = LRAR_ADDR_W,
  parameter logic [31:0] BASE = LRAR_C8_BASE,
  parameter int unsigned BLK_SHIFT = LRAR_REGION_SHIFT
)
(
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic write_in,
  input wire logic [1:0] route_sel_in,
  output logic hit_out,
  output logic local_out
);

  // =====================================================================
  // parameter checks
  if (ADDR_W > 32 || BLK_SHIFT == 0 || BLK_SHIFT >= ADDR_W)
  begin : g_shift_check
    $error("lrar_region_route: block shift must lie inside a 32-bit address");
  end

  // a base off the block grid would split one region over two blocks
  if ((BASE & ((32'h1 << BLK_SHIFT) - 32'h1)) != 32'h0)
  begin : g_base_check
    $error("lrar_region_route: region base must be block aligned");
  end

  // =====================================================================
  // block match
  logic [ADDR_W-BLK_SHIFT-1:0] addr_blk;
  logic [ADDR_W-BLK_SHIFT-1:0] base_blk;

  // comparing block numbers keeps each region exactly one block wide
  assign addr_blk = addr_in[ADDR_W-1:BLK_SHIFT];
  assign base_blk = BASE[ADDR_W-1:BLK_SHIFT];
  assign hit_out = (addr_blk == base_blk);

  // =====================================================================
  // steering: bit 0 keeps reads local, bit 1 keeps writes local
  // 00 all pci, 01 reads local, 10 writes local, 11 all local
  always_comb
  begin
    if (write_in)
    begin
      local_out = route_sel_in[LRAR_SEL_WR_BIT];
    end
    else
    begin
      local_out = route_sel_in[LRAR_SEL_RD_BIT];
    end
  end

endmodule

// *** dv/lrar_router_sva.sv ***
// assertions on the router ports
`timescale 1ns/100ps
module lrar_router_sva (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [31:0] mem_attr_in,
  input wire logic sdram_req_out,
  input wire logic pci_req_out,
  input wire logic other_req_out,
  input wire logic req_write_out,
  input wire logic [31:0] req_addr_out
);
  // ==========================================================
  // region decode over the full address, 16 KB pages
  wire logic v = req_valid_in;
  wire logic w = req_write_in;
  wire logic [17:0] pg = req_addr_in[31:14];
  wire logic hit = pg inside {18'h32, 18'h33, 18'h34};
  wire logic [1:0] s = mem_attr_in[2 * (pg[2:0] - 3'h2) + 8 +: 2];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  d0_read_a: assert property (
    v && pg == 18'h34 && !w |=> sdram_req_out == $past(mem_attr_in[12]))
    else $error("d0 read routed wrongly");
  cc_write_a: assert property (
    v && pg == 18'h33 && w |=> sdram_req_out == $past(mem_attr_in[11]))
    else $error("cc write routed wrongly");
  c8_read_a: assert property (
    v && pg == 18'h32 && !w |=> pci_req_out != $past(mem_attr_in[8]))
    else $error("c8 read routed wrongly");
  pci_both_a: assert property (v && hit && s == 2'h0 |=> pci_req_out && !sdram_req_out)
    else $error("setting 00 not on pci");
  rd_local_a: assert property (v && hit && s == 2'h1 |=> sdram_req_out != $past(w))
    else $error("setting 01 misrouted");
  wr_local_a: assert property (v && hit && s == 2'h2 |=> sdram_req_out == $past(w))
    else $error("setting 10 misrouted");
  local_both_a: assert property (v && hit && s == 2'h3 |=> sdram_req_out && !pci_req_out)
    else $error("setting 11 not on sdram");
  outside_route_a: assert property (
    v && !hit |=> other_req_out && !sdram_req_out && !pci_req_out)
    else $error("outside request misrouted");
  write_copy_a: assert property (
    1'b1 |=> req_write_out == $past(req_write_in))
    else $error("write flag copy wrong");
  addr_copy_a: assert property (
    1'b1 |=> req_addr_out == $past(req_addr_in))
    else $error("address copy wrong");
endmodule
bind lrar_router lrar_router_sva u_sva (.mclk_in, .rst_b_in, .req_valid_in, .req_write_in,
  .req_addr_in, .mem_attr_in, .sdram_req_out, .pci_req_out, .other_req_out,
  .req_write_out, .req_addr_out);

// *** dv/lrar_cpu_model.sv ***
// processor core model issuing single memory requests
`timescale 1ns/100ps
module lrar_cpu_model (
  input wire logic mclk_in,
  output logic req_valid_out = 1'b0,
  output logic req_write_out = 1'b0,
  output logic [31:0] req_addr_out = 32'h0
);
  // ==========================================================
  // idle lines show the inverse so a stale address is never trusted
  task automatic issue(input logic wr, input logic [31:0] adr);
    @(posedge mclk_in) #1;
    {req_valid_out, req_write_out, req_addr_out} = {1'b1, wr, adr};
    @(posedge mclk_in) #1;
    {req_valid_out, req_write_out, req_addr_out} = {1'b0, ~wr, ~adr};
  endtask
endmodule

// *** dv/legacy_region_access_router_tb_top.sv ***
// testbench for the legacy region access router
`timescale 1ns/100ps
module legacy_region_access_router_tb_top;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [31:0] attr = 32'h0;
  logic v, w, sd, pc, ot;
  logic [31:0] a;
  logic wo;
  logic [31:0] ao;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial
  begin
    forever #2 mclk_in = ~mclk_in;
  end
  lrar_cpu_model cpu (.mclk_in, .req_valid_out(v), .req_write_out(w), .req_addr_out(a));
  lrar_router DUT (.mclk_in, .rst_b_in, .req_valid_in(v), .req_write_in(w), .req_addr_in(a),
    .mem_attr_in(attr), .sdram_req_out(sd), .pci_req_out(pc), .other_req_out(ot),
    .req_write_out(wo), .req_addr_out(ao));
  // ==========================================================
  // checks and scenarios
  task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_copy(input string n, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // other fields hold the inverse setting so a wrong field shows
  task automatic t_regions;
    logic [1:0] s;
    logic [31:0] adr;
    for (int r = 0; r < 3; r++)
      for (int k = 0; k < 8; k++)
      begin
        s = k[2:1];
        attr = {16{~s}};
        attr[8 + 2 * r +: 2] = s;
        adr = 32'h000c8000 + 32'(r * 16384) + {18'h0, {14{k[0]}}};
        cpu.issue(k[0], adr);
        chk("route", s[k[0]] ? 3'b100 : 3'b010, {sd, pc, ot});
        chk_copy("copy", {k[0], adr}, {wo, ao});
      end
  endtask
  task automatic t_outside;
    attr = 32'hffffffff;
    cpu.issue(1'b0, 32'h000c7fff);
    chk("below", 3'b001, {sd, pc, ot});
    cpu.issue(1'b1, 32'h000d4000);
    chk("above", 3'b001, {sd, pc, ot});
    chk_copy("copy", {1'b1, 32'h000d4000}, {wo, ao});
    cpu.issue(1'b0, 32'h001d0000);
    chk("alias", 3'b001, {sd, pc, ot});
    @(posedge mclk_in) #1;
    chk("idle", 3'b000, {sd, pc, ot});
  endtask
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  initial
  begin
    repeat (2) @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    t_regions;
    t_outside;
    stop_test;
  end
endmodule
